// file: core/pmoc_defs.vh
// Overview of operation
// - two bits pick mode and polarity
// - registered mode drives pin from flip-flop
// - per-output true or inverted polarity
// - own product term drives tri-state enable
// - registered mode feeds back inverted register
// - registered pin is output only
// - combinatorial mode drives pin from sum
// - enable always on, off, or term
// - combinatorial feedback taken from pin side
// - holds 32-bit readable user signature
// - signature readable despite security bit
// - per-output open drain drives low only
// - one global input bias selection
// - erased bias setting means pull-up
// - per-output fast or slow slew
// - security bit refuses readback and programming
// - only full erase clears security bit (rst_b also clears it here)
// - power-up clears all registers within time
// - async clear term zeroes all registers
// - sync set term loads ones next edge
// - clear and set act on register state
`ifndef PMOC_DEFS_VH
`define PMOC_DEFS_VH
// arch select field positions inside a macrocell pair
`define PMOC_ARCH_LOW_POS 0
`define PMOC_ARCH_HIGH_POS 1
// arch_select_high: 1 = combinatorial, 0 = registered
`define PMOC_MODE_REG 1'b0
`define PMOC_MODE_COMB 1'b1
// arch_select_low: 1 = true (active high), 0 = inverted
`define PMOC_POL_INV 1'b0
`define PMOC_POL_TRUE 1'b1
// combinatorial enable source codes
`define PMOC_OE_TERM 2'h0
`define PMOC_OE_ON 2'h1
`define PMOC_OE_OFF 2'h2
// global bias codes, erased value is pull-up
`define PMOC_BIAS_PULLUP 2'h0
`define PMOC_BIAS_PULLDOWN 2'h1
`define PMOC_BIAS_KEEPER 2'h2
`define PMOC_BIAS_NONE 2'h3
`define PMOC_BIAS_RESET 2'h0
// slew codes
`define PMOC_SLEW_FAST 1'b1
// configuration operations
`define PMOC_OP_NONE 2'h0
`define PMOC_OP_PROG 2'h1
`define PMOC_OP_READ 2'h2
`define PMOC_OP_ERASE 2'h3
// power-up reset time in ns and the clock period in ns
`define PMOC_TPR_NS 1000
`define PMOC_CLK_NS 50
`define PMOC_TPR_CYC ((`PMOC_TPR_NS) / (`PMOC_CLK_NS))
`endif

// file: core/pmoc_cell.v
`timescale 1ns/1ns
`include "pmoc_defs.vh"
// one output macrocell: register, polarity, enable, feedback
module pmoc_cell (
  // clock and reset
  input wire clk,
  input wire rst_b,
  // shared clear and set
  input wire clear_all,
  input wire sync_set_term,
  // logic array terms
  input wire sum_term,
  input wire oe_term,
  // configuration
  input wire arch_select_low,
  input wire arch_select_high,
  input wire [1:0] oe_src,
  input wire open_drain_bit,
  // pin
  input wire pin_i,
  output wire pin_o,
  output wire pin_oe,
  // feedback to array
  output wire fb_true,
  output wire fb_comp,
  output wire reg_state
);
  reg q_r; // macrocell flip-flop
  wire comb_mode; // combinatorial select
  wire level; // level before the buffer
  reg oe_raw; // enable before open drain gating
  wire fb_src; // feedback source

  assign comb_mode = (arch_select_high == `PMOC_MODE_COMB);

  // register captures sum; clear acts at once, not at the edge, so it beats set
  // limitation: a glitch on the shared clear term also clears every register
  always @(posedge clk or negedge rst_b or posedge clear_all) begin
    if (!rst_b) begin
      q_r <= 1'b0;
    end else if (clear_all) begin
      q_r <= 1'b0;
    end else if (sync_set_term) begin
      q_r <= 1'b1;
    end else begin
      q_r <= sum_term;
    end
  end
  // polarity applies after the register, so clear/set pin level depends on it
  assign level = (comb_mode ? sum_term : q_r) ^ (arch_select_low == `PMOC_POL_INV);

  // enable source: registered always uses the term
  always @* begin
    oe_raw = oe_term;
    if (comb_mode) begin
      case (oe_src)
        `PMOC_OE_ON: oe_raw = 1'b1;
        `PMOC_OE_OFF: oe_raw = 1'b0;
        default: oe_raw = oe_term;
      endcase
    end
  end

  // open drain drives only a low
  assign pin_o = open_drain_bit ? 1'b0 : level;
  assign pin_oe = oe_raw & (~open_drain_bit | ~level);

  // registered feeds back /q, never the pin, so pin is output only
  assign fb_src = comb_mode ? pin_i : ~q_r;
  assign fb_true = fb_src;
  assign fb_comp = ~fb_src;
  assign reg_state = q_r;
endmodule

// file: core/pmoc_array.v
`timescale 1ns/1ns
`include "pmoc_defs.vh"
// output macrocell array with global options and configuration store
module pmoc_array #(
  parameter N_CELLS = 10,
  parameter SIG_W = 32,
  parameter TPR_CYC = `PMOC_TPR_CYC
) (
  // clock and reset
  input wire clk,
  input wire rst_b,
  // logic array terms (same clock domain)
  input wire [N_CELLS-1:0] sum_term,
  input wire [N_CELLS-1:0] oe_term,
  input wire async_clear_term,
  input wire sync_set_term,
  // pins
  input wire [N_CELLS-1:0] pin_i,
  output wire [N_CELLS-1:0] pin_o,
  output wire [N_CELLS-1:0] pin_oe,
  // feedback into the array
  output wire [N_CELLS-1:0] fb_true,
  output wire [N_CELLS-1:0] fb_comp,
  output wire [N_CELLS-1:0] reg_state,
  // configuration operation port
  input wire [1:0] cfg_op,
  input wire [N_CELLS-1:0] arch_select_low,
  input wire [N_CELLS-1:0] arch_select_high,
  input wire [2*N_CELLS-1:0] oe_src,
  input wire [N_CELLS-1:0] open_drain_bit,
  input wire [N_CELLS-1:0] slew_select_bit,
  input wire [1:0] bias_sel,
  input wire [SIG_W-1:0] sig_wdata,
  input wire security_set,
  // configuration status
  output reg cfg_refused,
  output reg [4*N_CELLS-1:0] cfg_rdata,
  output reg cfg_rvalid,
  output reg [SIG_W-1:0] user_signature,
  output reg security_bit,
  output reg [N_CELLS-1:0] slew_fast,
  output reg [1:0] bias_mode,
  output reg por_done
);
  localparam CW = 16;
  localparam [CW-1:0] TPR_LAST = TPR_CYC[CW-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // stored configuration
  reg [N_CELLS-1:0] arch_low_r; // polarity bits
  reg [N_CELLS-1:0] arch_high_r; // mode bits
  reg [2*N_CELLS-1:0] oe_src_r; // comb enable source
  reg [N_CELLS-1:0] od_r; // open drain bits
  reg [CW-1:0] por_cnt_r; // power-up counter
  wire prog_ok; // programming allowed
  wire clear_all; // async clear or power-up hold

  assign prog_ok = ~security_bit;

  // configuration store; a full erase or rst_b unlocks it
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      arch_low_r <= {N_CELLS{1'b0}};
      arch_high_r <= {N_CELLS{1'b0}};
      oe_src_r <= {2*N_CELLS{1'b0}};
      od_r <= {N_CELLS{1'b0}};
      slew_fast <= {N_CELLS{1'b0}};
      bias_mode <= `PMOC_BIAS_RESET;
      user_signature <= {SIG_W{1'b0}};
      security_bit <= 1'b0;
      cfg_refused <= 1'b0;
    end else begin
      cfg_refused <= 1'b0;
      case (cfg_op)
        `PMOC_OP_ERASE: begin
          // full erase wipes everything, security included
          arch_low_r <= {N_CELLS{1'b0}};
          arch_high_r <= {N_CELLS{1'b0}};
          oe_src_r <= {2*N_CELLS{1'b0}};
          od_r <= {N_CELLS{1'b0}};
          slew_fast <= {N_CELLS{1'b0}};
          bias_mode <= `PMOC_BIAS_RESET;
          user_signature <= {SIG_W{1'b0}};
          security_bit <= 1'b0;
        end
        `PMOC_OP_PROG: begin
          if (prog_ok) begin
            arch_low_r <= arch_select_low;
            arch_high_r <= arch_select_high;
            oe_src_r <= oe_src;
            od_r <= open_drain_bit;
            slew_fast <= slew_select_bit;
            bias_mode <= bias_sel;
            user_signature <= sig_wdata;
            security_bit <= security_set;
          end else begin
            cfg_refused <= 1'b1;
          end
        end
        `PMOC_OP_READ: begin
          cfg_refused <= security_bit;
        end
        default: begin
          cfg_refused <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // array readback; signature port stays live regardless of security
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_rdata <= {4*N_CELLS{1'b0}};
      cfg_rvalid <= 1'b0;
    end else begin
      cfg_rvalid <= (cfg_op == `PMOC_OP_READ) & prog_ok;
      if ((cfg_op == `PMOC_OP_READ) & prog_ok) begin
        cfg_rdata <= {arch_low_r, arch_high_r, oe_src_r};
      end else begin
        cfg_rdata <= {4*N_CELLS{1'b0}};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power-up reset: registers held clear for the reset time
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      por_cnt_r <= {CW{1'b0}};
      por_done <= 1'b0;
    end else if (!por_done) begin
      por_cnt_r <= por_cnt_r + 16'h0001;
      por_done <= (por_cnt_r >= TPR_LAST - 16'h0001);
    end
  end
  // registers held cleared until the power-up time has run out
  assign clear_all = async_clear_term | ~por_done;

  ////////////////////////////////////////////////////////////////////////////
  // one macrocell per output
  genvar g;
  generate
    for (g = 0; g < N_CELLS; g = g + 1) begin : g_cell
      pmoc_cell u_cell (
        .clk(clk),
        .rst_b(rst_b),
        .clear_all(clear_all),
        .sync_set_term(sync_set_term),
        .sum_term(sum_term[g]),
        .oe_term(oe_term[g]),
        .arch_select_low(arch_low_r[g]),
        .arch_select_high(arch_high_r[g]),
        .oe_src(oe_src_r[2*g+1:2*g]),
        .open_drain_bit(od_r[g]),
        .pin_i(pin_i[g]),
        .pin_o(pin_o[g]),
        .pin_oe(pin_oe[g]),
        .fb_true(fb_true[g]),
        .fb_comp(fb_comp[g]),
        .reg_state(reg_state[g])
      );
    end
  endgenerate
endmodule

// file: dv/pmoc_array_checker.sv
`timescale 1ns/1ns
`include "pmoc_defs.vh"
////////////////////////////////////////////////////////////////
// pin, register and setup checks seen from the array's ports
module pmoc_array_checker #(
  parameter N_CELLS = 10
) (
  // clock and reset
  input wire clk,
  input wire rst_b,
  // array terms
  input wire [N_CELLS-1:0] sum_term,
  input wire [N_CELLS-1:0] oe_term,
  input wire async_clear_term,
  input wire sync_set_term,
  // pins and feedback
  input wire [N_CELLS-1:0] pin_i,
  input wire [N_CELLS-1:0] pin_o,
  input wire [N_CELLS-1:0] pin_oe,
  input wire [N_CELLS-1:0] fb_true,
  input wire [N_CELLS-1:0] fb_comp,
  input wire [N_CELLS-1:0] reg_state,
  // setup port
  input wire [1:0] cfg_op,
  input wire [N_CELLS-1:0] arch_select_low,
  input wire [N_CELLS-1:0] arch_select_high,
  input wire [2*N_CELLS-1:0] oe_src,
  input wire [N_CELLS-1:0] open_drain_bit,
  input wire cfg_refused,
  input wire [4*N_CELLS-1:0] cfg_rdata,
  input wire cfg_rvalid,
  input wire security_bit,
  input wire por_done
);
  // shadow of the accepted setup, trusted only after a program
  reg [N_CELLS-1:0] lo_r, hi_r, od_r;
  reg [2*N_CELLS-1:0] src_r;
  reg cv_r;
  reg [N_CELLS-1:0] eoe;
  wire [N_CELLS-1:0] vm = ~od_r & {N_CELLS{cv_r}};
  // shadow follows accepted programs; erase leaves it untrusted
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cv_r <= 1'b0;
    end else if (cfg_op == `PMOC_OP_ERASE) begin
      cv_r <= 1'b0;
    end else if (cfg_op == `PMOC_OP_PROG && !security_bit) begin
      cv_r <= 1'b1;
      lo_r <= arch_select_low;
      hi_r <= arch_select_high;
      od_r <= open_drain_bit;
      src_r <= oe_src;
    end
  end
  // expected enable: register cells and code 0/3 follow the term
  always @* begin
    for (int i = 0; i < N_CELLS; i++) begin
      eoe[i] = (hi_r[i] && src_r[2*i+:2] == `PMOC_OE_ON) ||
        ((!hi_r[i] || src_r[2*i+:2] != `PMOC_OE_OFF) && oe_term[i]);
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  a_reg_pin: assert property (((pin_o ^ reg_state ^ ~lo_r) & vm & ~hi_r) == '0)
    else $error("registered pin level wrong");
  a_comb_pin: assert property (((pin_o ^ sum_term ^ ~lo_r) & vm & hi_r) == '0)
    else $error("combinatorial pin level wrong");
  a_oe_source: assert property (((pin_oe ^ eoe) & vm) == '0)
    else $error("pin enable wrong");
  a_open_drain: assert property ((pin_o & od_r & {N_CELLS{cv_r}}) == '0)
    else $error("open drain pin driven high");
  a_comb_fb: assert property ((((fb_true ^ pin_i) | (fb_comp ^ ~pin_i)) & hi_r & {N_CELLS{cv_r}}) == '0)
    else $error("pin feedback wrong");
  a_clear_wins: assert property (por_done && async_clear_term |=> reg_state == '0)
    else $error("clear did not zero registers");
  a_clear_now: assert property (async_clear_term |-> reg_state == '0)
    else $error("clear did not act at once");
  a_set_ones: assert property (por_done && sync_set_term && !async_clear_term |=>
    async_clear_term || reg_state == '1)
    else $error("set did not load ones");
  a_reg_capture: assert property (por_done && !async_clear_term && !sync_set_term |=>
    async_clear_term || reg_state == $past(sum_term))
    else $error("register missed sum");
  a_reg_fb: assert property ((((fb_true ^ ~reg_state) | (fb_comp ^ reg_state)) & ~hi_r & {N_CELLS{cv_r}}) == '0)
    else $error("register feedback wrong");
  a_refuse_op: assert property (security_bit && (cfg_op == `PMOC_OP_PROG || cfg_op == `PMOC_OP_READ) |=>
    cfg_refused && !cfg_rvalid && cfg_rdata == '0)
    else $error("secured operation not refused");
  a_read_back: assert property (cfg_op == `PMOC_OP_READ && !security_bit && cv_r |=>
    cfg_rvalid && cfg_rdata == {$past(lo_r), $past(hi_r), $past(src_r)})
    else $error("readback data wrong");
endmodule
bind pmoc_array pmoc_array_checker #(.N_CELLS(N_CELLS)) i_pmoc_array_checker (.clk(clk), .rst_b(rst_b),
  .sum_term(sum_term), .oe_term(oe_term), .async_clear_term(async_clear_term), .sync_set_term(sync_set_term),
  .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe), .fb_true(fb_true), .fb_comp(fb_comp), .reg_state(reg_state),
  .cfg_op(cfg_op), .arch_select_low(arch_select_low), .arch_select_high(arch_select_high), .oe_src(oe_src),
  .open_drain_bit(open_drain_bit), .cfg_refused(cfg_refused), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
  .security_bit(security_bit), .por_done(por_done));

// file: dv/pmoc_board.sv
`timescale 1ns/1ns
// board side of the pins: weak pull-up plus optional outside drivers
module pmoc_board #(
  parameter N = 10
) (
  // device side
  input wire [N-1:0] pin_o,
  input wire [N-1:0] pin_oe,
  // outside drivers, only heard where the device lets go
  input wire [N-1:0] ext_v,
  input wire [N-1:0] ext_en,
  // resolved level
  output wire [N-1:0] pin_i
);
  // released, undriven pins rise through the erased pull-up
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & ((ext_en & ext_v) | ~ext_en));
endmodule

// file: dv/pmoc_array_tb.sv
`timescale 1ns/1ns
`include "pmoc_defs.vh"
module pmoc_array_tb;
  localparam N = 10;
  reg clk = 1'b0;
  reg rst_b = 1'b0;
  reg [N-1:0] sum = '0, oet = '0, lo = '0, hi = '0, od = '0, sl = '0, ext_v = '0, ext_en = '0, exp_q;
  reg [2*N-1:0] src = '0;
  reg [1:0] op = '0, bias = '0;
  reg [31:0] sig = '0, ts;
  reg clr = 1'b0, set = 1'b0, sec = 1'b0;
  wire [N-1:0] pin_i, pin_o, pin_oe, q, slewf;
  wire [4*N-1:0] rdata;
  wire [31:0] usig;
  wire [1:0] biasm;
  wire refused, rvalid, secb, pdone;
  integer fails = 0, cmp_count = 0, j, k;
  always #25 clk = ~clk;
  pmoc_array #(.N_CELLS(N), .TPR_CYC(2)) i_pmoc_array (.clk(clk), .rst_b(rst_b), .sum_term(sum), .oe_term(oet),
    .async_clear_term(clr), .sync_set_term(set), .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe), .fb_true(),
    .fb_comp(), .reg_state(q), .cfg_op(op), .arch_select_low(lo), .arch_select_high(hi), .oe_src(src),
    .open_drain_bit(od), .slew_select_bit(sl), .bias_sel(bias), .sig_wdata(sig), .security_set(sec),
    .cfg_refused(refused), .cfg_rdata(rdata), .cfg_rvalid(rvalid), .user_signature(usig), .security_bit(secb),
    .slew_fast(slewf), .bias_mode(biasm), .por_done(pdone));
  pmoc_board #(.N(N)) i_pmoc_board (.pin_o(pin_o), .pin_oe(pin_oe), .ext_v(ext_v), .ext_en(ext_en), .pin_i(pin_i));
  task chk(input string nm, input logic [63:0] seen, input logic [63:0] want);
    cmp_count++;
    if (seen !== want) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, want, seen);
    end
  endtask
  task conclude;
    if (fails == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // clear beats set, set beats the sum
  function automatic [N-1:0] next_q(input [N-1:0] d, input cl, input st);
    next_q = cl ? '0 : (st ? '1 : d);
  endfunction
  // one setup operation; a program brings fresh random fields
  task do_op(input [1:0] code, input logic sv, input [1:0] b);
    integer i;
    @(posedge clk);
    op <= code;
    if (code == `PMOC_OP_PROG) begin
      lo <= $urandom;
      hi <= $urandom;
      od <= $urandom & $urandom;
      sl <= $urandom;
      sig <= $urandom;
      sec <= sv;
      bias <= b;
      for (i = 0; i < N; i++) src[2*i+:2] <= $urandom % 4;
    end
    @(posedge clk);
    op <= `PMOC_OP_NONE;
    @(negedge clk);
  endtask
  // random terms and outside drive, register checked every cycle
  task run(input integer n);
    integer c;
    for (c = 0; c < n; c++) begin
      @(posedge clk);
      exp_q = next_q(sum, clr, set);
      sum <= $urandom;
      oet <= $urandom;
      ext_v <= $urandom;
      ext_en <= $urandom;
      clr <= ($urandom % 16) == 0;
      set <= ($urandom % 8) == 0;
      @(negedge clk);
      // clear is asynchronous: a newly raised clear empties the register mid-cycle
      chk("reg_state", q, clr ? {N{1'b0}} : exp_q);
    end
  endtask
  initial begin
    void'($urandom(32'h5b6eac0e));
    // power rise: reset stands in for it, every input is held still meanwhile
    repeat (5) @(posedge clk);
    chk("reset_pins", pin_o, {N{1'b1}});
    chk("reset_bias", biasm, `PMOC_BIAS_PULLUP);
    rst_b <= 1'b1;
    // no capture traffic until power-up reset is over
    for (k = 0; k < 6 && pdone !== 1'b1; k++) @(posedge clk);
    chk("por_done", pdone, 1'b1);
    for (j = 0; j < 4; j++) begin
      do_op(`PMOC_OP_PROG, 1'b0, j);
      chk("user_signature", usig, sig);
      chk("slew_fast", slewf, sl);
      chk("bias_mode", biasm, bias);
      do_op(`PMOC_OP_READ, 1'b0, 2'h0);
      chk("read_valid", rvalid, 1'b1);
      chk("read_data", rdata, {lo, hi, src});
      @(posedge clk);
      clr <= 1'b1;
      set <= 1'b1;
      run(60);
    end
    do_op(`PMOC_OP_PROG, 1'b1, 2'h1);
    ts = sig;
    chk("security_bit", secb, 1'b1);
    do_op(`PMOC_OP_PROG, 1'b0, 2'h2);
    chk("prog_refused", refused, 1'b1);
    chk("security_kept", secb, 1'b1);
    chk("sig_kept", usig, ts);
    do_op(`PMOC_OP_READ, 1'b0, 2'h0);
    chk("read_refused", refused, 1'b1);
    chk("read_valid", rvalid, 1'b0);
    do_op(`PMOC_OP_ERASE, 1'b0, 2'h0);
    chk("erased_security", secb, 1'b0);
    chk("erased_bias", biasm, `PMOC_BIAS_PULLUP);
    run(20);
    conclude;
  end
  initial begin
    #(50 * 3000);
    fails++;
    conclude;
  end
endmodule
